/* File: inc/smfx_pkg.sv */
// constants, field layouts and types for the fifo/move/flag executor
// assumes one system clock; shared by the design and its bench
package smfx_pkg;

	// ====================================================================
	// register offsets on the plain register port
	localparam logic [3:0] OFS_CONFIG = 4'h0;
	localparam logic [3:0] OFS_IRQ = 4'h1;
	localparam logic [3:0] OFS_INTE = 4'h2;
	localparam logic [3:0] OFS_STATUS = 4'h3;
	localparam logic [3:0] OFS_X = 4'h4;
	localparam logic [3:0] OFS_Y = 4'h5;
	localparam logic [3:0] OFS_INPUT_SHIFT_REG = 4'h6;
	localparam logic [3:0] OFS_OUTPUT_SHIFT_REG = 4'h7;

	// ====================================================================
	// field positions
	localparam int CFG_ITHR_LSB = 0;
	localparam int CFG_OTHR_LSB = 5;
	localparam int CFG_STSEL_BIT = 10;
	localparam int CFG_INBASE_LSB = 11;
	localparam int CFG_OUTBASE_LSB = 16;
	localparam int CFG_SETBASE_LSB = 21;
	localparam int CFG_APULL_BIT = 26;
	localparam int CFG_SSCNT_LSB = 27;
	localparam int INTE_L1_LSB = 4;
	localparam int STS_STALL_BIT = 0;
	localparam int STS_ICNT_LSB = 8;
	localparam int STS_OCNT_LSB = 16;
	localparam int STS_BUSY_BIT = 24;

	// ====================================================================
	// reset values and counts
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [7:0] INTE_RST = 8'h00;
	localparam logic [5:0] FULL_COUNT = 6'h20;

	// ====================================================================
	// instruction encodings
	localparam logic [2:0] OPC_FIFO = 3'h4;
	localparam logic [2:0] OPC_MOV = 3'h5;
	localparam logic [2:0] OPC_IRQ = 3'h6;
	localparam logic [2:0] OPC_SET = 3'h7;
	localparam logic [2:0] DST_PINS = 3'h0;
	localparam logic [2:0] DST_X = 3'h1;
	localparam logic [2:0] DST_Y = 3'h2;
	localparam logic [2:0] DST_RUN_DATA_AS_INSTRUCTION = 3'h4;
	localparam logic [2:0] DST_PC = 3'h5;
	localparam logic [2:0] DST_INPUT_SHIFT_REG = 3'h6;
	localparam logic [2:0] DST_OUTPUT_SHIFT_REG = 3'h7;
	localparam logic [2:0] SET_PINDIRS = 3'h4;
	localparam logic [2:0] SRC_PINS = 3'h0;
	localparam logic [2:0] SRC_X = 3'h1;
	localparam logic [2:0] SRC_Y = 3'h2;
	localparam logic [2:0] SRC_NULL = 3'h3;
	localparam logic [2:0] SRC_STATUS = 3'h5;
	localparam logic [2:0] SRC_INPUT_SHIFT_REG = 3'h6;
	localparam logic [2:0] SRC_OUTPUT_SHIFT_REG = 3'h7;
	localparam logic [1:0] MOP_INV = 2'h1;
	localparam logic [1:0] MOP_REV = 2'h2;

	typedef enum logic [1:0] {ST_IDLE, ST_RUN_DATA_AS_INSTRUCTION, ST_IRQW, ST_DELAY} smfx_state_t;

endpackage

/* File: logic/smfx_run_data_as_instruction.sv */
// executor for the rx enqueue, tx dequeue, copy, flag and immediate-write
// instructions of one state machine
// assumes: fetch logic on clk offers instructions, fifos are on clk,
// pins arrive asynchronously
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module smfx_run_data_as_instruction import smfx_pkg::*; #(
	parameter int MACHINE_ID = 0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic instr_valid,
	input wire logic [15:0] instr,
	output logic instr_ready,
	output logic pc_load,
	output logic [4:0] pc_value,
	output logic rx_push,
	output logic [31:0] rx_data,
	input wire logic rx_full,
	output logic tx_pop,
	input wire logic [31:0] tx_data,
	input wire logic tx_empty,
	input wire logic [31:0] pins_in,
	output logic [31:0] pins_out,
	output logic [31:0] pins_mask,
	output logic pins_we,
	output logic [31:0] pindirs_out,
	output logic [31:0] pindirs_mask,
	output logic pindirs_we,
	input wire logic [7:0] irq_ack,
	output logic [7:0] irq_flags,
	output logic irq_line0,
	output logic irq_line1
);

	// refused at elaboration: relative flag indexing only serves four machines
	if (MACHINE_ID < 0 || MACHINE_ID > 3) begin : g_bad_id
		$error("MACHINE_ID must lie in 0..3");
	end

	localparam logic [1:0] SM_NUM = 2'(MACHINE_ID);

	// ====================================================================
	// helpers
	function automatic logic thr_hit(input logic [5:0] cnt, input logic [4:0] thr);
		logic [5:0] lim;
		lim = (thr == 5'h00) ? FULL_COUNT : {1'b0, thr};
		return cnt >= lim;
	endfunction

	function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] s);
		logic [63:0] t;
		t = {v, v} << s;
		return t[63:32];
	endfunction

	function automatic logic [31:0] rotr(input logic [31:0] v, input logic [4:0] s);
		logic [63:0] t;
		t = {v, v} >> s;
		return t[31:0];
	endfunction

	function automatic logic [31:0] bitrev(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int n = 0; n < 32; n++) begin
			r[n] = v[31 - n];
		end
		return r;
	endfunction

	// ====================================================================
	// state
	smfx_state_t state;
	smfx_state_t next_state;
	logic [15:0] cur;
	logic [4:0] dcnt;
	logic [31:0] cfg;
	logic [7:0] inte;
	logic [31:0] x;
	logic [31:0] y;
	logic [31:0] input_shift_reg;
	logic [31:0] output_shift_reg;
	logic [5:0] icnt;
	logic [5:0] ocnt;
	logic stall_flag;
	logic [31:0] pin_meta;
	logic [31:0] pin_sync;

	// ====================================================================
	// configuration fields
	logic [4:0] ithr;
	logic [4:0] othr;
	logic status_sel;
	logic [4:0] in_base;
	logic [4:0] out_base;
	logic [4:0] set_base;
	logic apull;
	logic [2:0] sscnt;
	assign ithr = cfg[CFG_ITHR_LSB +: 5];
	assign othr = cfg[CFG_OTHR_LSB +: 5];
	assign status_sel = cfg[CFG_STSEL_BIT];
	assign in_base = cfg[CFG_INBASE_LSB +: 5];
	assign out_base = cfg[CFG_OUTBASE_LSB +: 5];
	assign set_base = cfg[CFG_SETBASE_LSB +: 5];
	assign apull = cfg[CFG_APULL_BIT];
	assign sscnt = cfg[CFG_SSCNT_LSB +: 3];

	// ====================================================================
	// decode
	logic in_run_data_as_instruction;
	logic [2:0] opc;
	logic [2:0] dst;
	logic [2:0] src;
	logic [4:0] dly;
	logic [2:0] fidx;
	logic [7:0] fbit;
	assign in_run_data_as_instruction = (state == ST_RUN_DATA_AS_INSTRUCTION);
	assign opc = cur[15:13];
	assign dst = cur[7:5];
	assign src = cur[2:0];
	// side-set bits take the top of the field, leaving the rest as delay
	assign dly = (sscnt > 3'h5) ? 5'h00 : (cur[12:8] & (5'h1f >> sscnt));
	// bit 2 passes through untouched, only the low pair is relative
	assign fidx = {cur[2], cur[4] ? (cur[1:0] + SM_NUM) : cur[1:0]};
	assign fbit = 8'h01 << fidx;

	logic is_fifo;
	logic is_mov;
	logic is_irq;
	logic is_set;
	assign is_fifo = in_run_data_as_instruction && (opc == OPC_FIFO);
	assign is_mov = in_run_data_as_instruction && (opc == OPC_MOV);
	assign is_irq = in_run_data_as_instruction && (opc == OPC_IRQ);
	assign is_set = in_run_data_as_instruction && (opc == OPC_SET);

	// enqueue / dequeue
	logic push_act;
	logic do_push;
	logic push_lost;
	logic push_stall;
	logic pull_act;
	logic do_pull;
	logic pull_x;
	logic pull_stall;
	assign push_act = is_fifo && !cur[7] && !(cur[6] && !thr_hit(icnt, ithr));
	assign push_stall = push_act && cur[5] && rx_full;
	assign do_push = push_act && !rx_full;
	assign push_lost = push_act && !cur[5] && rx_full;
	// a full output register under automatic refill makes the dequeue a no-op
	assign pull_act = is_fifo && cur[7] && !(apull && ocnt == 6'h00)
		&& !(cur[6] && !thr_hit(ocnt, othr));
	assign pull_stall = pull_act && cur[5] && tx_empty;
	assign do_pull = pull_act && !tx_empty;
	assign pull_x = pull_act && !cur[5] && tx_empty;

	// copy source and operation
	logic status_bit;
	logic [31:0] msrc;
	logic [31:0] mval;
	assign status_bit = status_sel ? rx_full : tx_empty;
	always_comb begin
		case (src)
			SRC_PINS: msrc = rotr(pin_sync, in_base);
			SRC_X: msrc = x;
			SRC_Y: msrc = y;
			SRC_NULL: msrc = 32'h0000_0000;
			SRC_STATUS: msrc = {32{status_bit}};
			SRC_INPUT_SHIFT_REG: msrc = input_shift_reg;
			SRC_OUTPUT_SHIFT_REG: msrc = output_shift_reg;
			default: msrc = 32'h0000_0000;
		endcase
		case (cur[4:3])
			MOP_INV: mval = ~msrc;
			MOP_REV: mval = bitrev(msrc);
			default: mval = msrc;
		endcase
	end

	// flag instruction
	logic irq_raise;
	logic irq_lower;
	logic irq_wait;
	logic wait_done;
	assign irq_raise = is_irq && !cur[6];
	assign irq_lower = is_irq && cur[6];
	assign irq_wait = irq_raise && cur[5];
	assign wait_done = (state == ST_IRQW) && !irq_flags[fidx];

	logic run_data_as_instruction_next;
	logic finish;
	assign run_data_as_instruction_next = is_mov && dst == DST_RUN_DATA_AS_INSTRUCTION;
	assign finish = (in_run_data_as_instruction && !push_stall && !pull_stall && !run_data_as_instruction_next && !irq_wait)
		|| wait_done;

	// ====================================================================
	// sequencing
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (instr_valid) begin
					next_state = ST_RUN_DATA_AS_INSTRUCTION;
				end
			end
			ST_RUN_DATA_AS_INSTRUCTION, ST_IRQW: begin
				if (irq_wait) begin
					next_state = ST_IRQW;
				end else if (finish) begin
					// delay starts only once the wait is over
					next_state = (dly != 5'h00) ? ST_DELAY : ST_IDLE;
				end
			end
			ST_DELAY: begin
				if (dcnt == 5'h01) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_IDLE;
			instr_ready <= 1'b0;
		end else begin
			state <= next_state;
			instr_ready <= (next_state == ST_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cur <= 16'h0000;
		end else if (state == ST_IDLE && instr_valid) begin
			cur <= instr;
		end else if (run_data_as_instruction_next) begin
			// the copied word runs next cycle; the copy's own delay is dropped
			cur <= mval[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dcnt <= 5'h00;
		end else if (finish) begin
			dcnt <= dly;
		end else if (state == ST_DELAY) begin
			dcnt <= dcnt - 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pc_load <= 1'b0;
			pc_value <= 5'h00;
		end else begin
			pc_load <= is_mov && dst == DST_PC;
			if (is_mov && dst == DST_PC) begin
				pc_value <= mval[4:0];
			end
		end
	end

	// ====================================================================
	// shift registers and fifo strobes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			input_shift_reg <= 32'h0000_0000;
			icnt <= 6'h00;
		end else if (do_push || push_lost) begin
			input_shift_reg <= 32'h0000_0000;
			icnt <= 6'h00;
		end else if (is_mov && dst == DST_INPUT_SHIFT_REG) begin
			input_shift_reg <= mval;
			icnt <= 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rx_push <= 1'b0;
			rx_data <= 32'h0000_0000;
		end else begin
			rx_push <= do_push;
			if (do_push) begin
				rx_data <= input_shift_reg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			output_shift_reg <= 32'h0000_0000;
			ocnt <= FULL_COUNT;
		end else if (do_pull) begin
			output_shift_reg <= tx_data;
			ocnt <= 6'h00;
		end else if (pull_x) begin
			output_shift_reg <= x;
			ocnt <= 6'h00;
		end else if (is_mov && dst == DST_OUTPUT_SHIFT_REG) begin
			output_shift_reg <= mval;
			ocnt <= 6'h00;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tx_pop <= 1'b0;
		end else begin
			tx_pop <= do_pull;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			x <= 32'h0000_0000;
			y <= 32'h0000_0000;
		end else begin
			if (is_mov && dst == DST_X) begin
				x <= mval;
			end else if (is_set && dst == DST_X) begin
				x <= {27'h0000000, cur[4:0]};
			end
			if (is_mov && dst == DST_Y) begin
				y <= mval;
			end else if (is_set && dst == DST_Y) begin
				y <= {27'h0000000, cur[4:0]};
			end
		end
	end

	// ====================================================================
	// pins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pin_meta <= 32'h0000_0000;
			pin_sync <= 32'h0000_0000;
		end else begin
			pin_meta <= pins_in;
			pin_sync <= pin_meta;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pins_out <= 32'h0000_0000;
			pins_mask <= 32'h0000_0000;
			pins_we <= 1'b0;
			pindirs_out <= 32'h0000_0000;
			pindirs_mask <= 32'h0000_0000;
			pindirs_we <= 1'b0;
		end else begin
			pins_we <= 1'b0;
			pindirs_we <= 1'b0;
			if (is_mov && dst == DST_PINS) begin
				pins_out <= rotl(mval, out_base);
				pins_mask <= 32'hffff_ffff;
				pins_we <= 1'b1;
			end else if (is_set && dst == DST_PINS) begin
				pins_out <= rotl({27'h0000000, cur[4:0]}, set_base);
				pins_mask <= rotl(32'h0000_001f, set_base);
				pins_we <= 1'b1;
			end
			if (is_set && dst == SET_PINDIRS) begin
				pindirs_out <= rotl({27'h0000000, cur[4:0]}, set_base);
				pindirs_mask <= rotl(32'h0000_001f, set_base);
				pindirs_we <= 1'b1;
			end
		end
	end

	// ====================================================================
	// flags; a raise in the same cycle as any clear wins
	logic sw_irq_clr;
	assign sw_irq_clr = reg_wr && reg_addr == OFS_IRQ;
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_flags <= 8'h00;
		end else begin
			irq_flags <= (irq_flags
				& ~(sw_irq_clr ? reg_wdata[7:0] : 8'h00)
				& ~irq_ack
				& ~(irq_lower ? fbit : 8'h00))
				| (irq_raise ? fbit : 8'h00);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_line0 <= 1'b0;
			irq_line1 <= 1'b0;
		end else begin
			// only the low four flags ever reach the system lines
			irq_line0 <= |(irq_flags[3:0] & inte[3:0]);
			irq_line1 <= |(irq_flags[3:0] & inte[INTE_L1_LSB +: 4]);
		end
	end

	// ====================================================================
	// register port
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cfg <= CFG_RST;
			inte <= INTE_RST;
		end else if (reg_wr) begin
			if (reg_addr == OFS_CONFIG) begin
				cfg <= reg_wdata;
			end
			if (reg_addr == OFS_INTE) begin
				inte <= reg_wdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			stall_flag <= 1'b0;
		end else if (push_lost) begin
			stall_flag <= 1'b1;
		end else if (reg_wr && reg_addr == OFS_STATUS && reg_wdata[STS_STALL_BIT]) begin
			stall_flag <= 1'b0;
		end
	end

	logic [31:0] sts_word;
	always_comb begin
		sts_word = 32'h0000_0000;
		sts_word[STS_STALL_BIT] = stall_flag;
		sts_word[STS_ICNT_LSB +: 6] = icnt;
		sts_word[STS_OCNT_LSB +: 6] = ocnt;
		sts_word[STS_BUSY_BIT] = (state != ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				OFS_CONFIG: reg_rdata <= cfg;
				OFS_IRQ: reg_rdata <= {24'h000000, irq_flags};
				OFS_INTE: reg_rdata <= {24'h000000, inte};
				OFS_STATUS: reg_rdata <= sts_word;
				OFS_X: reg_rdata <= x;
				OFS_Y: reg_rdata <= y;
				OFS_INPUT_SHIFT_REG: reg_rdata <= input_shift_reg;
				OFS_OUTPUT_SHIFT_REG: reg_rdata <= output_shift_reg;
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

endmodule

/* File: test/smfx_run_data_as_instruction_props.sv */
// assertions on the executor's top-level ports
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module smfx_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic pc_load,
	input wire logic rx_push,
	input wire logic tx_pop,
	input wire logic rx_full,
	input wire logic tx_empty,
	input wire logic pins_we,
	input wire logic pindirs_we,
	input wire logic [7:0] irq_flags,
	input wire logic irq_line0,
	input wire logic irq_line1
);
	// ====================================================================
	// properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_push_once;
		rx_push |=> !rx_push;
	endproperty
	a_push_once: assert property (p_push_once) else $error("push wider than one cycle");
	property p_push_room;
		rx_push |-> !$past(rx_full);
	endproperty
	a_push_room: assert property (p_push_room) else $error("push into a full fifo");
	property p_pop_data;
		tx_pop |-> !$past(tx_empty) ##1 !tx_pop;
	endproperty
	a_pop_data: assert property (p_pop_data) else $error("pop from an empty fifo");
	property p_take;
		instr_valid && instr_ready |=> !instr_ready;
	endproperty
	a_take: assert property (p_take) else $error("ready held after take");
	property p_idle_quiet;
		instr_ready && $past(instr_ready) |-> !(rx_push || tx_pop || pc_load || pins_we);
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("effect without instruction");
	property p_jump;
		pc_load |-> !$past(instr_ready) ##1 !pc_load;
	endproperty
	a_jump: assert property (p_jump) else $error("jump without copy");
	property p_line_src;
		irq_line0 || irq_line1 |-> $past(irq_flags[3:0]) != 4'h0;
	endproperty
	a_line_src: assert property (p_line_src) else $error("line without low flag");
	property p_line_high;
		$past(irq_flags[3:0]) == 4'h0 |-> !irq_line0 && !irq_line1;
	endproperty
	a_line_high: assert property (p_line_high) else $error("high flag reached a line");
	property p_pin_write;
		pins_we |-> !pindirs_we ##1 !pins_we;
	endproperty
	a_pin_write: assert property (p_pin_write) else $error("pin write malformed");
endmodule

bind smfx_run_data_as_instruction smfx_props smfx_props_inst (.clk(clk), .reset_n(reset_n),
	.instr_valid(instr_valid), .instr_ready(instr_ready), .pc_load(pc_load),
	.rx_push(rx_push), .tx_pop(tx_pop), .rx_full(rx_full), .tx_empty(tx_empty),
	.pins_we(pins_we), .pindirs_we(pindirs_we), .irq_flags(irq_flags),
	.irq_line0(irq_line0), .irq_line1(irq_line1));

/* File: test/smfx_fifo_model.sv */
// receive and transmit fifos as the host side sees them
// assumes the bench plays the processor through host_rd and host_wr
`timescale 1ns/1ps
module smfx_fifo_model #(
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rx_push,
	input wire logic [31:0] rx_data,
	output logic rx_full,
	input wire logic tx_pop,
	output logic [31:0] tx_data,
	output logic tx_empty,
	input wire logic host_rd,
	output logic [31:0] host_rdata,
	output int rx_level,
	input wire logic host_wr,
	input wire logic [31:0] host_wdata
);
	logic [31:0] rxq[$];
	logic [31:0] txq[$];
	// ====================================================================
	// queues; an empty transmit head toggles so a stale word is never read as valid, an empty receive head reads zero
	always @(posedge clk) begin
		if (!reset_n) begin
			rxq.delete();
			txq.delete();
		end else begin
			if (rx_push && rxq.size() < DEPTH)
				rxq.push_back(rx_data);
			if (host_rd && rxq.size() > 0)
				void'(rxq.pop_front());
			if (tx_pop && txq.size() > 0)
				void'(txq.pop_front());
			if (host_wr)
				txq.push_back(host_wdata);
		end
		rx_full <= rxq.size() >= DEPTH;
		rx_level <= rxq.size();
		host_rdata <= (rxq.size() > 0) ? rxq[0] : 32'h0;
		tx_empty <= txq.size() == 0;
		tx_data <= (txq.size() > 0) ? txq[0] : ~tx_data;
	end
endmodule

/* File: test/tb_smfx_run_data_as_instruction.sv */
// self-checking bench for the executor with a fifo model at its far side
// assumes machine number 2 and a two-deep receive fifo
`timescale 1ns/1ps
module tb_smfx_run_data_as_instruction import smfx_pkg::*;;
	logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, instr_valid = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0, pins_in = 32'h8000_0001, host_wdata = 32'h0;
	logic [15:0] instr = 16'h0;
	logic [7:0] irq_ack = 8'h0, irq_flags;
	logic host_rd = 0, host_wr = 0;
	logic [31:0] reg_rdata, rx_data, tx_data, pins_out, pins_mask, pindirs_out, pindirs_mask;
	logic [31:0] host_rdata, v, pins_seen, dirs_seen;
	logic [4:0] pc_value, pc_seen;
	logic instr_ready, pc_load, rx_push, rx_full, tx_pop, tx_empty, pins_we, pindirs_we;
	logic irq_line0, irq_line1;
	int rx_level, fails = 0, tests_run = 0;
	typedef struct {logic [31:0] cfg; logic [15:0] ins; logic [3:0] ra; logic [31:0] exp;} smfx_row_t;
	smfx_row_t rows[13] = '{
		'{32'h0, 16'he035, OFS_X, 32'h15}, '{32'h0, 16'ha049, OFS_Y, 32'hffffffea},
		'{32'h0, 16'ha032, OFS_X, 32'h57ffffff},
		'{32'h0, 16'ha0c1, OFS_INPUT_SHIFT_REG, 32'h57ffffff},
		'{32'h0, 16'ha024, OFS_X, 32'h0}, '{32'h0, 16'he05f, OFS_Y, 32'h1f},
		'{32'h0, 16'ha03a, OFS_X, 32'h1f}, '{32'h0, 16'ha045, OFS_Y, 32'hffffffff},
		'{32'h400, 16'ha045, OFS_Y, 32'h0}, '{32'h0, 16'ha020, OFS_X, 32'h80000001},
		'{32'h800, 16'ha020, OFS_X, 32'hc0000000},
		'{32'h0, 16'ha0e1, OFS_OUTPUT_SHIFT_REG, 32'hc0000000},
		'{32'h0, 16'h4021, OFS_X, 32'hc0000000}};
	logic [4:0] idx[5] = '{5'h00, 5'h11, 5'h13, 5'h16, 5'h07};
	int bit_of[5] = '{0, 3, 1, 4, 7};

	always #12.5 clk = ~clk;
	smfx_run_data_as_instruction #(.MACHINE_ID(2)) smfx_run_data_as_instruction_inst (.clk(clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .instr_valid(instr_valid), .instr(instr),
		.instr_ready(instr_ready), .pc_load(pc_load), .pc_value(pc_value),
		.rx_push(rx_push), .rx_data(rx_data), .rx_full(rx_full), .tx_pop(tx_pop),
		.tx_data(tx_data), .tx_empty(tx_empty), .pins_in(pins_in), .pins_out(pins_out),
		.pins_mask(pins_mask), .pins_we(pins_we), .pindirs_out(pindirs_out),
		.pindirs_mask(pindirs_mask), .pindirs_we(pindirs_we), .irq_ack(irq_ack),
		.irq_flags(irq_flags), .irq_line0(irq_line0), .irq_line1(irq_line1));
	smfx_fifo_model #(.DEPTH(2)) smfx_fifo_model_inst (.clk(clk), .reset_n(reset_n),
		.rx_push(rx_push), .rx_data(rx_data), .rx_full(rx_full), .tx_pop(tx_pop),
		.tx_data(tx_data), .tx_empty(tx_empty), .host_rd(host_rd),
		.host_rdata(host_rdata), .rx_level(rx_level), .host_wr(host_wr),
		.host_wdata(host_wdata));

	always @(posedge clk) begin
		if (pc_load) pc_seen <= pc_value;
		if (pins_we) pins_seen <= pins_out & pins_mask;
		if (pindirs_we) dirs_seen <= pindirs_out & pindirs_mask;
	end

	// ====================================================================
	// tasks
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk) reg_wr <= 0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk) reg_rd <= 0;
		#1 v = reg_rdata;
	endtask
	// the word stays offered until ready is seen high at an edge
	task ex(input logic [15:0] i);
		int n;
		@(posedge clk) {instr, instr_valid} <= {i, 1'b1};
		for (n = 0; n < 64 && instr_ready !== 1'b1; n++) @(posedge clk);
		@(posedge clk) instr_valid <= 0;
		// read right after an edge, ready holds the value the design sampled there
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (instr_ready === 1'b1) break;
		end
		chk("ready", instr_ready, 1);
		repeat (2) @(posedge clk);
		#1;
	endtask
	task host(input logic w, input logic [31:0] d);
		@(posedge clk) {host_wr, host_rd, host_wdata} <= {w, !w, d};
		@(posedge clk) {host_wr, host_rd} <= 2'b00;
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		stop_test();
	end

	// ====================================================================
	// sequence
	initial begin
		repeat (4) @(posedge clk);
		reset_n <= 1;
		rd(OFS_STATUS);
		chk("ocnt", 32'(v[STS_OCNT_LSB+:6]), 32'h20);
		foreach (rows[k]) begin
			wr(OFS_CONFIG, rows[k].cfg);
			ex(rows[k].ins);
			rd(rows[k].ra);
			chk("row", v, rows[k].exp);
		end
		$display("table done");
		ex(16'ha0c1);
		ex(16'h8020);
		chk("rxword", host_rdata, 32'hc0000000);
		rd(OFS_INPUT_SHIFT_REG);
		chk("input_shift_reg", v, 0);
		ex(16'ha0c1);
		wr(OFS_CONFIG, 32'h1);
		ex(16'h8060);
		rd(OFS_INPUT_SHIFT_REG);
		chk("input_shift_reg", v, 32'hc0000000);
		wr(OFS_CONFIG, 32'h0);
		ex(16'h8020);
		ex(16'ha0c1);
		ex(16'h8000);
		chk("level", rx_level, 2);
		rd(OFS_INPUT_SHIFT_REG);
		chk("input_shift_reg", v, 0);
		rd(OFS_STATUS);
		chk("stall", v[STS_STALL_BIT], 1);
		ex(16'ha0c1);
		fork
			ex(16'h8020);
			begin
				repeat (8) @(posedge clk);
				chk("stalled", instr_ready, 0);
				host(0, 0);
			end
		join
		chk("level", rx_level, 2);
		$display("push done");
		host(1, 32'h1234a5a5);
		host(1, 32'h0f0f7777);
		ex(16'h80a0);
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'h1234a5a5);
		wr(OFS_CONFIG, 32'h20);
		ex(16'h80e0);
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'h1234a5a5);
		wr(OFS_CONFIG, 32'h04000000);
		ex(16'h80a0);
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'h1234a5a5);
		wr(OFS_CONFIG, 32'h0);
		ex(16'h80a0);
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'h0f0f7777);
		ex(16'h8080);
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'hc0000000);
		fork
			ex(16'h80a0);
			begin
				repeat (8) @(posedge clk);
				chk("stalled", instr_ready, 0);
				host(1, 32'h55550001);
			end
		join
		rd(OFS_OUTPUT_SHIFT_REG);
		chk("output_shift_reg", v, 32'h55550001);
		$display("pull done");
		ex(16'he053);
		ex(16'ha0a2);
		chk("pc", 32'(pc_seen), 32'h13);
		@(posedge clk) pins_in <= 32'h0000e03a;
		ex(16'ha040);
		ex(16'ha082);
		rd(OFS_X);
		chk("run_data_as_instruction", v, 32'h1a);
		ex(16'ha001);
		chk("pins", pins_seen, 32'h1a);
		ex(16'he09f);
		chk("dirs", dirs_seen, 32'h1f);
		$display("copy done");
		wr(OFS_INTE, 32'h21);
		foreach (idx[k]) begin
			ex(16'hc000 | 16'(idx[k]));
			chk("flag", irq_flags, 32'(8'h1 << bit_of[k]));
			chk("line0", irq_line0, k == 0);
			ex(16'hc060 | 16'(idx[k]));
			chk("flag", irq_flags, 0);
		end
		ex(16'hc001);
		chk("line1", irq_line1, 1);
		wr(OFS_IRQ, 32'h2);
		fork
			ex(16'hc121);
			begin
				repeat (8) @(posedge clk);
				chk("waiting", instr_ready, 0);
				@(posedge clk) irq_ack <= 8'h2;
				@(posedge clk) irq_ack <= 8'h0;
			end
		join
		chk("flag", irq_flags, 0);
		$display("flags done");
		stop_test();
	end
endmodule
